// ==== core/uenc_pkg.sv ====
// Purpose: shared constants and types of the endpoint-0 request and nak block
// Assumes: 32-bit apb data, registers on aligned words
// Notes:   every register offset, register field position and latency used by the logic lives here
package uenc_pkg;
    // register byte addresses
    localparam logic [15:0] NAK_CTRL_ADDR  = 16'hff60; // endpoint0_nak_control
    localparam logic [15:0] FCLR_A_ADDR    = 16'hff64; // fifo_clear_ctrl_a
    localparam logic [15:0] FCLR_B_ADDR    = 16'hff68; // fifo_clear_ctrl_b
    localparam logic [15:0] IRQ_STAT_ADDR  = 16'hff6c; // sticky event status
    localparam logic [15:0] IRQ_EN_ADDR    = 16'hff70; // event enables
    localparam logic [15:0] IRQ_CLR_ADDR   = 16'hff74; // write-one-to-clear
    // nak control fields and reset value
    localparam int          WR_NAK_BIT     = 0;        // ep0_write_dir_nak
    localparam int          RD_NAK_BIT     = 1;        // ep0_read_dir_nak
    localparam logic [7:0]  NAK_CTRL_RST   = 8'h00;
    // fifo clear fields
    localparam int          FCLR_EP0_BIT   = 0;
    // interrupt event fields
    localparam int          EV_DECODE_BIT  = 0;        // cpu_request_decode_irq
    localparam int          EV_STALL_BIT   = 1;        // automatic stall sent
    localparam int          EV_W           = 2;
    // status latency after a fifo clear write, in usb clocks
    localparam int          CLR_LATENCY    = 5;
    // setup packet fields
    localparam logic [1:0]  TYPE_STANDARD  = 2'h0;
    localparam logic [4:0]  RCP_DEVICE     = 5'h00;
    localparam logic [4:0]  RCP_INTERFACE  = 5'h01;
    localparam logic [4:0]  RCP_ENDPOINT   = 5'h02;
    localparam logic [7:0]  REQ_GET_STATUS = 8'h00;
    localparam logic [7:0]  REQ_CLR_FEAT   = 8'h01;
    localparam logic [7:0]  REQ_SET_FEAT   = 8'h03;
    localparam logic [7:0]  REQ_SET_ADDR   = 8'h05;
    localparam logic [7:0]  REQ_GET_DESC   = 8'h06;
    localparam logic [7:0]  REQ_SET_DESC   = 8'h07;
    localparam logic [7:0]  REQ_GET_CONF   = 8'h08;
    localparam logic [7:0]  REQ_SET_CONF   = 8'h09;
    localparam logic [7:0]  REQ_GET_IF     = 8'h0a;
    localparam logic [7:0]  REQ_SET_IF     = 8'h0b;
    localparam logic [7:0]  DESC_STRING    = 8'h03;

    // true for status and feature requests
    function automatic logic is_stat_feat(input logic [7:0] r);
        return (r == REQ_GET_STATUS) || (r == REQ_CLR_FEAT) || (r == REQ_SET_FEAT);
    endfunction

    // apb slave phase
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACC  = 2'b10
    } uenc_bus_t;
endpackage

// ==== core/uenc_req_decode.sv ====
// Purpose: classify a received setup request for endpoint 0
// Assumes: setup fields stay valid while setup_valid is high
// Notes:   purely combinational; the top registers the stall and firmware results, hw_auto only feeds an assertion
`timescale 1ns/1ps
module uenc_req_decode (
    input  wire logic [7:0] req_type,
    input  wire logic [7:0] request,
    input  wire logic [7:0] desc_type,
    output logic            auto_stall,
    output logic            hw_auto,
    output logic            cpu_decode
);
    logic       std;  // standard request type
    logic [4:0] rcp;  // recipient field
    logic       known; // requests executed by other hardware

    // sort into stall, hardware-executed, or firmware
    always_comb begin
        std        = (req_type[6:5] == uenc_pkg::TYPE_STANDARD);
        rcp        = req_type[4:0];
        known      = 1'b0;
        auto_stall = 1'b0;
        hw_auto    = 1'b0;
        cpu_decode = 1'b0;
        if (std && uenc_pkg::is_stat_feat(request)) begin
            known = (rcp == uenc_pkg::RCP_DEVICE) || (rcp == uenc_pkg::RCP_ENDPOINT);
        end else if (std && request == uenc_pkg::REQ_GET_DESC) begin
            known = (desc_type != uenc_pkg::DESC_STRING); // string goes to firmware
        end else if (std) begin
            known = (request == uenc_pkg::REQ_SET_ADDR) || (request == uenc_pkg::REQ_GET_CONF)
                 || (request == uenc_pkg::REQ_SET_CONF) || (request == uenc_pkg::REQ_GET_IF)
                 || (request == uenc_pkg::REQ_SET_IF);
        end
        if (std && uenc_pkg::is_stat_feat(request) && rcp == uenc_pkg::RCP_INTERFACE) begin
            auto_stall = 1'b1;
        end else if (known) begin
            hw_auto = 1'b1;
        end else begin
            cpu_decode = 1'b1;
        end
    end
endmodule

// ==== core/uenc_clr_delay.sv ====
// Purpose: delay fifo clear launches by a fixed number of cycles
// Assumes: one launch bit per clear register
// Notes:   back to back launches are all carried
`timescale 1ns/1ps
module uenc_clr_delay #(
    parameter int LAT = uenc_pkg::CLR_LATENCY
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] launch,
    output logic      [1:0] done
);
    // refuse a latency the shift line cannot hold
    if (LAT < 2) begin : g_chk
        $error("uenc_clr_delay: LAT must be at least 2");
    end

    typedef struct packed {
        logic [LAT-1:0][1:0] pipe; // one entry per cycle of latency
    } uenc_dly_state_t;

    uenc_dly_state_t s_q;
    uenc_dly_state_t s_d;

    // shift launches toward the output
    always_comb begin
        s_d = s_q;
        s_d.pipe = {s_q.pipe[LAT-2:0], launch};
    end

    // register the state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.pipe[LAT-1];
endmodule

// ==== core/uenc_top.sv ====
// Purpose: endpoint-0 request routing and nak control with apb registers
// Assumes: usb-side strobes are synchronous to pclk, which is the usb clock
// Notes:   one-cycle apb access phase; events gated onto a level interrupt
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps

module uenc_top #(
    parameter int ADDR_W = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              setup_valid,
    input  wire logic [7:0]        setup_req_type,
    input  wire logic [7:0]        setup_request,
    input  wire logic [7:0]        setup_desc_type,
    input  wire logic              nak_tx_busy,
    input  wire logic              ep0_data_end,
    input  wire logic              in_token,
    input  wire logic              in_ack,
    output logic                   irq,
    output logic                   stall_resp,
    output logic                   cpu_request_decode_irq,
    output logic                   ep0_read_dir_nak,
    output logic                   ep0_write_dir_nak,
    output logic                   in_data_send
);
    // refuse an address bus too narrow for the map
    if (ADDR_W < 16) begin : g_chk
        $error("uenc_top: ADDR_W must be at least 16");
    end

    typedef struct packed {
        uenc_pkg::uenc_bus_t        bus;      // apb phase
        logic [31:0]                prdata;   // read data
        logic                       pready;   // access answer
        logic                       pslverr;  // access error
        logic                       rd_nak;   // read-direction nak flag
        logic                       wr_nak;   // write-direction nak flag
        logic                       cpu_xfer; // current transfer owned by firmware
        logic [uenc_pkg::EV_W-1:0]  ist;      // sticky events
        logic [uenc_pkg::EV_W-1:0]  ien;      // event enables
        logic                       irq;      // interrupt level
        logic                       stall;    // stall pulse
        logic                       dec;      // decode pulse
        logic                       in_send;  // data send pulse
        logic                       rd_nak_o; // read nak as shown on the pin
        logic                       wr_nak_o; // write nak as shown on the pin
    } uenc_top_state_t;

    uenc_top_state_t s_q;
    uenc_top_state_t s_d;

    logic        dec_stall;   // request stalls automatically
    logic        dec_hw;      // request run by other hardware
    logic        dec_cpu;     // request goes to firmware
    logic [1:0]  clr_launch;  // fifo clear writes this cycle
    logic [1:0]  clr_done;    // fifo clear takes effect now
    logic        acc;         // access phase edge of a transfer
    logic        wr_en;       // write takes effect
    logic        setup_cpu;   // firmware-owned setup now
    logic        setup_stall; // stalling setup now
    logic [15:0] addr;        // low address bits
    logic [7:0]  nak_rd;      // nak register read view

    // request classifier
    uenc_req_decode u_dec (
        .req_type   (setup_req_type),
        .request    (setup_request),
        .desc_type  (setup_desc_type),
        .auto_stall (dec_stall),
        .hw_auto    (dec_hw),
        .cpu_decode (dec_cpu)
    );

    // fifo clear latency line
    uenc_clr_delay #(
        .LAT (uenc_pkg::CLR_LATENCY)
    ) u_dly (
        .pclk    (pclk),
        .presetn (presetn),
        .launch  (clr_launch),
        .done    (clr_done)
    );

    // decode the bus and the usb strobes
    always_comb begin
        addr        = paddr[15:0];
        acc         = psel && penable && s_q.pready;
        wr_en       = acc && pwrite && !s_q.pslverr;
        setup_cpu   = setup_valid && dec_cpu;
        setup_stall = setup_valid && dec_stall;
        clr_launch  = 2'b00;
        if (wr_en && addr == uenc_pkg::FCLR_A_ADDR) begin
            clr_launch[0] = pwdata[uenc_pkg::FCLR_EP0_BIT];
        end
        if (wr_en && addr == uenc_pkg::FCLR_B_ADDR) begin
            clr_launch[1] = pwdata[uenc_pkg::FCLR_EP0_BIT];
        end
        nak_rd = uenc_pkg::NAK_CTRL_RST;
        nak_rd[uenc_pkg::RD_NAK_BIT] = s_q.rd_nak;
        nak_rd[uenc_pkg::WR_NAK_BIT] = s_q.wr_nak;
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.stall   = 1'b0;
        s_d.dec     = 1'b0;
        s_d.in_send = 1'b0;
        // apb slave, answer in the first access cycle
        case (s_q.bus)
            uenc_pkg::BUS_IDLE: begin
                s_d.pready  = 1'b0;
                s_d.pslverr = 1'b0;
                if (psel && !penable) begin
                    s_d.bus    = uenc_pkg::BUS_ACC;
                    s_d.pready = 1'b1;
                    s_d.prdata = 32'h0000_0000;
                    if (paddr[1:0] != 2'h0) begin
                        s_d.pslverr = 1'b1; // unaligned
                    end else if (pwrite && addr == uenc_pkg::NAK_CTRL_ADDR && !pstrb[0]) begin
                        s_d.pslverr = 1'b1;
                    end else if (pwrite && pstrb == 4'h0) begin
                        s_d.pslverr = 1'b1; // empty write
                    end else begin
                        case (addr)
                            uenc_pkg::NAK_CTRL_ADDR: begin
                                s_d.prdata = {24'h00_0000, nak_rd};
                            end
                            uenc_pkg::IRQ_STAT_ADDR: begin
                                s_d.prdata = {30'h0000_0000, s_q.ist};
                            end
                            uenc_pkg::IRQ_EN_ADDR: begin
                                s_d.prdata = {30'h0000_0000, s_q.ien};
                            end
                            uenc_pkg::FCLR_A_ADDR,
                            uenc_pkg::FCLR_B_ADDR,
                            uenc_pkg::IRQ_CLR_ADDR: begin
                                s_d.prdata = 32'h0000_0000; // write-only
                            end
                            default: begin
                                s_d.pslverr = 1'b1; // unmapped
                            end
                        endcase
                    end
                end
            end
            uenc_pkg::BUS_ACC: begin
                if (acc) begin
                    s_d.bus     = uenc_pkg::BUS_IDLE;
                    s_d.pready  = 1'b0;
                    s_d.pslverr = 1'b0;
                end
            end
            default: begin
                s_d.bus    = uenc_pkg::BUS_IDLE;
                s_d.pready = 1'b0;
            end
        endcase
        // enable register
        if (wr_en && addr == uenc_pkg::IRQ_EN_ADDR) begin
            s_d.ien = pwdata[uenc_pkg::EV_W-1:0];
        end
        // event clear, then new events win
        if (wr_en && addr == uenc_pkg::IRQ_CLR_ADDR) begin
            s_d.ist = s_q.ist & ~pwdata[uenc_pkg::EV_W-1:0];
        end
        if (setup_cpu) begin
            s_d.ist[uenc_pkg::EV_DECODE_BIT] = 1'b1;
        end
        if (setup_stall) begin
            s_d.ist[uenc_pkg::EV_STALL_BIT] = 1'b1;
        end
        // usb-side answers to a setup
        if (setup_valid) begin
            s_d.cpu_xfer = dec_cpu;
            s_d.dec      = dec_cpu;
            s_d.stall    = dec_stall;
        end
        // read nak: firmware write unless nak is being sent
        if (wr_en && addr == uenc_pkg::NAK_CTRL_ADDR && !nak_tx_busy) begin
            s_d.rd_nak = pwdata[uenc_pkg::RD_NAK_BIT];
        end
        if (clr_done[0]) begin
            s_d.rd_nak = 1'b0;
        end
        if (setup_cpu) begin
            s_d.rd_nak = 1'b1;
        end
        // write nak: hardware only, firmware writes have no effect
        if (in_ack || clr_done[1]) begin
            s_d.wr_nak = 1'b0;
        end
        if (ep0_data_end) begin
            s_d.wr_nak = 1'b1;
        end
        // prepared data leaves on each in token while the write nak is set and firmware owns the transfer
        if (in_token && s_q.wr_nak && s_q.cpu_xfer) begin
            s_d.in_send = 1'b1;
        end
        s_d.irq = |(s_d.ist & s_d.ien);
        // nak pins registered here, gated by firmware ownership, so no gate sits behind the flop
        s_d.rd_nak_o = s_d.rd_nak && s_d.cpu_xfer;
        s_d.wr_nak_o = s_d.wr_nak && s_d.cpu_xfer;
    end

    // register the state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q     <= '0;
            s_q.bus <= uenc_pkg::BUS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign prdata                 = s_q.prdata;
    assign pready                 = s_q.pready;
    assign pslverr                = s_q.pslverr;
    assign irq                    = s_q.irq;
    assign stall_resp             = s_q.stall;
    assign cpu_request_decode_irq = s_q.dec;
    assign ep0_read_dir_nak       = s_q.rd_nak_o;
    assign ep0_write_dir_nak      = s_q.wr_nak_o;
    assign in_data_send           = s_q.in_send;

    // nak register write while nak not busy
    sequence nak_write_free;
        wr_en && addr == uenc_pkg::NAK_CTRL_ADDR && !nak_tx_busy;
    endsequence

    // fifo clear a launched
    sequence clr_a_write;
        wr_en && addr == uenc_pkg::FCLR_A_ADDR && pwdata[uenc_pkg::FCLR_EP0_BIT];
    endsequence

    chk_decode_irq: assert property (@(posedge pclk) disable iff (!presetn)
        setup_cpu |=> cpu_request_decode_irq && s_q.ist[uenc_pkg::EV_DECODE_BIT])
        else $error("decode request did not raise the decode event");

    chk_auto_stall: assert property (@(posedge pclk) disable iff (!presetn)
        setup_stall |=> stall_resp && !cpu_request_decode_irq)
        else $error("interface status request not stalled");

    chk_nak_gated: assert property (@(posedge pclk) disable iff (!presetn)
        setup_valid && (dec_hw || dec_stall) |=> !ep0_read_dir_nak && !ep0_write_dir_nak)
        else $error("nak shown for a hardware request");

    chk_byte_access: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && pwrite && paddr[1:0] == 2'h0 && addr == uenc_pkg::NAK_CTRL_ADDR && !pstrb[0]
        |=> pready && pslverr)
        else $error("narrow nak register write accepted");

    chk_wr_nak_ro: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && addr == uenc_pkg::NAK_CTRL_ADDR && !ep0_data_end && !in_ack && !clr_done[1]
        |=> s_q.wr_nak == $past(s_q.wr_nak))
        else $error("firmware write changed the write nak bit");

    chk_clr_latency: assert property (@(posedge pclk) disable iff (!presetn)
        clr_a_write |-> ##5 clr_done[0] ##1 (!s_q.rd_nak || $past(setup_cpu)))
        else $error("fifo clear not seen after five clocks");

    chk_rd_nak_wr: assert property (@(posedge pclk) disable iff (!presetn)
        nak_write_free ##0 (!clr_done[0] && !setup_cpu)
        |=> s_q.rd_nak == $past(pwdata[uenc_pkg::RD_NAK_BIT]))
        else $error("free nak write not stored");

    chk_busy_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && addr == uenc_pkg::NAK_CTRL_ADDR && nak_tx_busy && !clr_done[0] && !setup_cpu
        |=> $stable(s_q.rd_nak))
        else $error("nak write taken while nak being sent");

    chk_in_send: assert property (@(posedge pclk) disable iff (!presetn)
        in_token && ep0_write_dir_nak |=> in_data_send)
        else $error("prepared data not sent on in token");

    chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && addr == uenc_pkg::NAK_CTRL_ADDR |-> prdata[31:2] == 30'h0000_0000)
        else $error("nak register upper bits not zero");

    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == |(s_q.ist & s_q.ien))
        else $error("interrupt level does not follow enabled events");
endmodule

// ==== tb/uenc_host_model.sv ====
// Purpose: usb host stand-in that issues setup packets, in tokens and handshakes
// Assumes: every task is entered just after a rising pclk edge
// Notes:   setup fields show inverted values outside the valid cycle
`timescale 1ns/1ps
module uenc_host_model (
    input  wire logic       pclk,
    output logic            setup_valid,
    output logic [7:0]      setup_req_type,
    output logic [7:0]      setup_request,
    output logic [7:0]      setup_desc_type,
    output logic            nak_tx_busy,
    output logic            in_token,
    output logic            in_ack
);
    // quiet bus at time zero
    initial begin
        setup_valid     = 1'b0;
        setup_req_type  = 8'h5a;
        setup_request   = 8'ha5;
        setup_desc_type = 8'h5a;
        nak_tx_busy     = 1'b0;
        in_token        = 1'b0;
        in_ack          = 1'b0;
    end
    // one setup packet; fields are junk once the valid cycle is over
    task automatic send_setup(input logic [7:0] rt, input logic [7:0] rq, input logic [7:0] dt);
        setup_valid     <= 1'b1;
        setup_req_type  <= rt;
        setup_request   <= rq;
        setup_desc_type <= dt;
        @(posedge pclk);
        setup_valid     <= 1'b0;
        setup_req_type  <= ~rt;
        setup_request   <= ~rq;
        setup_desc_type <= ~dt;
    endtask
    // one-cycle in token, or acknowledge of the data sent
    task automatic pulse_in(input logic ack);
        if (ack) begin
            in_ack <= 1'b1;
        end else begin
            in_token <= 1'b1;
        end
        @(posedge pclk);
        in_ack   <= 1'b0;
        in_token <= 1'b0;
    endtask
    // level telling that nak is going out on the read side
    task automatic set_busy(input logic b);
        nak_tx_busy <= b;
    endtask
endmodule

// ==== tb/usb_ep0_request_nak_control_test.sv ====
// Purpose: self-checking bench of the endpoint-0 request and nak block
// Assumes: one wait-free apb access cycle, pulses one cycle after their cause
// Notes:   firmware side and ep0_data_end are driven directly, the other usb signals through the host model
`timescale 1ns/1ps
module usb_ep0_request_nak_control_test;
    logic        pclk;                          // 100 mhz clock
    logic        presetn;                       // async reset, active low
    logic        psel, penable, pwrite;         // apb request
    logic [15:0] paddr;                         // apb byte address
    logic [31:0] pwdata, prdata;                // apb data
    logic [3:0]  pstrb;                         // apb strobes
    logic        pready, pslverr;               // apb answer
    logic        setup_valid, nak_tx_busy, in_token, in_ack, ep0_data_end;
    logic [7:0]  setup_req_type, setup_request, setup_desc_type;
    logic        irq, stall_resp, cpu_request_decode_irq, ep0_read_dir_nak, ep0_write_dir_nak, in_data_send;
    logic [31:0] rdata_seen;                    // read data taken at the answer edge
    logic        err_seen;                      // error flag taken at the answer edge
    int          err_count = 0;
    int          n_tests   = 0;
    // request type, request, descriptor type, stall expected, decode expected
    logic [25:0] req_tbl [7] = '{{8'h81, 8'h00, 8'h00, 2'b10}, {8'h01, 8'h01, 8'h00, 2'b10},
                                 {8'h01, 8'h03, 8'h00, 2'b10}, {8'h80, 8'h06, 8'h03, 2'b01},
                                 {8'h00, 8'h07, 8'h00, 2'b01}, {8'h00, 8'h05, 8'h00, 2'b00},
                                 {8'h40, 8'h01, 8'h00, 2'b01}};

    uenc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .setup_valid(setup_valid), .setup_req_type(setup_req_type), .setup_request(setup_request),
        .setup_desc_type(setup_desc_type), .nak_tx_busy(nak_tx_busy), .ep0_data_end(ep0_data_end),
        .in_token(in_token), .in_ack(in_ack), .irq(irq), .stall_resp(stall_resp),
        .cpu_request_decode_irq(cpu_request_decode_irq), .ep0_read_dir_nak(ep0_read_dir_nak),
        .ep0_write_dir_nak(ep0_write_dir_nak), .in_data_send(in_data_send));
    uenc_host_model host (.pclk(pclk), .setup_valid(setup_valid), .setup_req_type(setup_req_type),
        .setup_request(setup_request), .setup_desc_type(setup_desc_type), .nak_tx_busy(nak_tx_busy),
        .in_token(in_token), .in_ack(in_ack));

    // free-running clock
    always #5 pclk = ~pclk;

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; an idle edge first so psel is never driven twice in one step,
    // then the request is held until pready is seen at an edge; only the watchdog ends a wait
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata_seen = prdata;
        err_seen   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // read a register and compare the word
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hf);
        check(rdata_seen, exp);
    endtask
    // write a fifo clear register and watch the flag move on the fifth edge
    task automatic lat_chk(input logic [15:0] a, input logic wr_side);
        apb(1'b1, a, 32'h1, 4'hf);
        for (int k = 1; k <= 5; k++) begin
            @(posedge pclk);
            #1;
            check(32'(wr_side ? ep0_write_dir_nak : ep0_read_dir_nak), 32'(k < 5));
        end
        @(posedge pclk);
        rd_chk(uenc_pkg::NAK_CTRL_ADDR, 32'h0);
    endtask

    // every request class gives its own response
    task automatic t_decode;
        for (int i = 0; i < 7; i++) begin
            host.send_setup(req_tbl[i][25:18], req_tbl[i][17:10], req_tbl[i][9:2]);
            #1;
            check(32'(stall_resp), 32'(req_tbl[i][1]));
            check(32'(cpu_request_decode_irq), 32'(req_tbl[i][0]));
            check(32'(ep0_read_dir_nak), 32'(req_tbl[i][0]));
            @(posedge pclk);
        end
        check(32'(ep0_read_dir_nak), 32'h1);
        $display("test decode done");
    endtask
    // byte access, read-only bit, reserved bits, writes ignored while busy
    task automatic t_nak_reg;
        apb(1'b1, uenc_pkg::NAK_CTRL_ADDR, 32'hff, 4'h1);
        rd_chk(uenc_pkg::NAK_CTRL_ADDR, 32'h2);
        apb(1'b1, uenc_pkg::NAK_CTRL_ADDR, 32'h0, 4'h1);
        rd_chk(uenc_pkg::NAK_CTRL_ADDR, 32'h0);
        host.set_busy(1'b1);
        apb(1'b1, uenc_pkg::NAK_CTRL_ADDR, 32'h2, 4'h1);
        host.set_busy(1'b0);
        rd_chk(uenc_pkg::NAK_CTRL_ADDR, 32'h0);
        apb(1'b1, uenc_pkg::NAK_CTRL_ADDR, 32'h2, 4'h0);
        check(32'(err_seen), 32'h1);
        rd_chk(uenc_pkg::NAK_CTRL_ADDR, 32'h0);
        rd_chk(16'hff7c, 32'h0);
        check(32'(err_seen), 32'h1);
        $display("test nak register done");
    endtask
    // write nak set by data end, in token, ack, then both delayed clears
    task automatic t_write_nak;
        ep0_data_end <= 1'b1;
        @(posedge pclk);
        ep0_data_end <= 1'b0;
        rd_chk(uenc_pkg::NAK_CTRL_ADDR, 32'h1);
        apb(1'b1, uenc_pkg::NAK_CTRL_ADDR, 32'h0, 4'h1);
        rd_chk(uenc_pkg::NAK_CTRL_ADDR, 32'h1);
        host.pulse_in(1'b0);
        #1;
        check(32'(in_data_send), 32'h1);
        @(posedge pclk);
        host.pulse_in(1'b1);
        #1;
        check(32'(ep0_write_dir_nak), 32'h0);
        @(posedge pclk);
        ep0_data_end <= 1'b1;
        @(posedge pclk);
        ep0_data_end <= 1'b0;
        lat_chk(uenc_pkg::FCLR_B_ADDR, 1'b1);
        apb(1'b1, uenc_pkg::NAK_CTRL_ADDR, 32'h2, 4'h1);
        lat_chk(uenc_pkg::FCLR_A_ADDR, 1'b0);
        $display("test write nak done");
    endtask
    // sticky events, enable mask and clear
    task automatic t_irq;
        apb(1'b1, uenc_pkg::IRQ_CLR_ADDR, 32'h3, 4'hf);
        apb(1'b1, uenc_pkg::IRQ_EN_ADDR, 32'h1, 4'hf);
        host.send_setup(8'h40, 8'h01, 8'h00);
        @(posedge pclk);
        #1;
        check(32'(irq), 32'h1);
        @(posedge pclk);
        host.send_setup(8'h81, 8'h00, 8'h00);
        @(posedge pclk);
        rd_chk(uenc_pkg::IRQ_STAT_ADDR, 32'h3);
        apb(1'b1, uenc_pkg::IRQ_EN_ADDR, 32'h0, 4'hf);
        @(posedge pclk);
        #1;
        check(32'(irq), 32'h0);
        @(posedge pclk);
        apb(1'b1, uenc_pkg::IRQ_EN_ADDR, 32'h1, 4'hf);
        apb(1'b1, uenc_pkg::IRQ_CLR_ADDR, 32'h1, 4'hf);
        @(posedge pclk);
        #1;
        check(32'(irq), 32'h0);
        @(posedge pclk);
        rd_chk(uenc_pkg::IRQ_STAT_ADDR, 32'h2);
        $display("test interrupt done");
    endtask

    // print counts and verdict, then stop
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog at 20000 cycles, far beyond the expected run of about 130 cycles
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end

    // reset, then the scenarios in order
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, ep0_data_end} = 4'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'({ep0_read_dir_nak, ep0_write_dir_nak, irq}), 32'h0);
        rd_chk(uenc_pkg::NAK_CTRL_ADDR, 32'(uenc_pkg::NAK_CTRL_RST));
        t_decode();
        t_nak_reg();
        t_write_nak();
        t_irq();
        tally_and_finish();
    end
endmodule
